// [design/gicx_pkg.sv]
/*
 * gicx_pkg: constants, field layouts and carrier types shared by the
 * global interrupt-context block and its receive buffer.
 * assumes: host offsets are 7-bit internal addresses, data is 8 bits.
 */
package gicx_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [6:0] OFS_SERVICED_CHANNEL_NUMBER = 7'h41;
	localparam logic [6:0] OFS_ACK_LEVEL_MODEM_GROUP   = 7'h61;
	localparam logic [6:0] OFS_ACK_LEVEL_TRANSMIT_GRP  = 7'h62;
	localparam logic [6:0] OFS_ACK_LEVEL_RECEIVE_GROUP = 7'h63;
	localparam logic [6:0] OFS_CHANNEL_SELECT          = 7'h64;
	localparam logic [6:0] OFS_FIRMWARE_REVISION       = 7'h6b;
	localparam logic [6:0] OFS_TICK_PRESCALE_HIGH      = 7'h70;
	localparam logic [6:0] OFS_TICK_PRESCALE_LOW       = 7'h71;
	localparam logic [6:0] OFS_RX_BYTE_POP             = 7'h78;
	localparam logic [6:0] OFS_RX_CHAR_CONDITION       = 7'h7a;
	localparam logic [6:0] OFS_SERVICE_DONE            = 7'h7f;

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int         SCN_CHAN_LSB     = 2;
	localparam logic [7:0] SCN_USER_MASK    = 8'he3;
	localparam int         CSEL_CHAN_W      = 3;
	localparam int         CSEL_ADDR_W      = 4;
	localparam logic [7:0] PRESCALE_RST     = 8'hff;
	localparam logic [7:0] ACK_LEVEL_RST    = 8'h00;
	localparam logic [7:0] CSEL_RST         = 8'h00;
	localparam logic [7:0] SCN_RST          = 8'h00;
	localparam logic [7:0] READ_IDLE_VALUE  = 8'h00;

	// ------------------------------------------------------------------
	// interrupt group codes
	// ------------------------------------------------------------------
	localparam logic [2:0] GRP_NONE         = 3'h0;
	localparam logic [2:0] GRP_MODEM        = 3'h1;
	localparam logic [2:0] GRP_TRANSMIT     = 3'h2;
	localparam logic [2:0] GRP_RX_GOOD      = 3'h3;
	localparam logic [2:0] GRP_RX_EXCEPTION = 3'h7;

	// ------------------------------------------------------------------
	// special character codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SC_NONE          = 3'h0;
	localparam logic [2:0] SC_FIRST         = 3'h1;
	localparam logic [2:0] SC_SECOND        = 3'h2;
	localparam logic [2:0] SC_THIRD         = 3'h3;
	localparam logic [2:0] SC_FOURTH        = 3'h4;

	localparam int         RX_FIFO_DEPTH    = 8;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_SERVICE = 2'b10
	} gicx_state_t;

	typedef struct packed {
		logic       timeout;
		logic [2:0] special_char_match_code;
		logic       brk;
		logic       parity_error_flag;
		logic       framing_error_flag;
		logic       overrun;
	} gicx_cond_t;

	typedef struct packed {
		gicx_cond_t cond;
		logic [7:0] data;
	} gicx_entry_t;

	localparam int ENTRY_W = $bits(gicx_entry_t);

	// one character from the receive engine
	typedef struct packed {
		logic [7:0] data;
		logic       brk;
		logic       parity_error_flag;
		logic       framing_error_flag;
		logic [2:0] match_index;
		logic       seq_matched;
		logic       seq_second;
		logic       pair13_en;
		logic       pair24_en;
	} gicx_rx_char_t;

endpackage : gicx_pkg

// [design/gicx_fifo.sv]
/*
 * gicx_fifo: parameterised first-in first-out buffer, show-ahead head.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module gicx_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} gicx_fifo_st_t;

	gicx_fifo_st_t    s_r;
	gicx_fifo_st_t    s_nxt;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : inc

	assign in_ready  = (s_r.cnt != (AW + 1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data  = mem_r[s_r.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
			s_nxt.wp = inc(s_r.wp);
		if (pop)
			s_nxt.rp = inc(s_r.rp);
		s_nxt.cnt = (AW + 1)'(s_r.cnt + {{AW{1'b0}}, push}
			- {{AW{1'b0}}, pop});
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
		if (push)
			mem_r[s_r.wp] <= in_data;
	end

endmodule : gicx_fifo

// [design/gicx_global_ctx.sv]
/*
 * gicx_global_ctx: global host registers of the serial controller, the
 * acknowledge matcher, the tick prescaler and the receive virtual
 * registers with their data/status buffer.
 * assumes: host strobes and scanner/receiver signals are synchronous to
 * clk_sys; the testbench samples data_out directly and does not use data_oe.
 */
`timescale 1ns/1ps

// Operation
// - serviced channel bits 4-2 show acknowledged channel, other bits user-held
// - first level code selects modem change group on acknowledge
// - second level code selects transmit data group on acknowledge
// - third level code selects receive data group on acknowledge
// - all eight level bits compared, bit 7 against a constant one
// - outside service channel select bits 3-0 form channel address
// - in service the interrupting channel replaces the channel select
// - firmware revision is read-only, loaded at initialisation
// - two prescale registers give reload of system-clock tick prescaler
// - hardware reset sets both prescale registers to ff
// - acknowledge switches serviced channel context into global registers
// - receive data read returns next byte and advances shared pointer
// - condition read returns status paired with current character
// - timeout entry when buffer empty and idle, no character attached
// - special code 0 none, 1/2 first/second, 3/4 only unpaired
// - no match on parity or framing error; pair second never overruns
// - char arriving when full is dropped, overrun marked on last one
// - group code 1 modem, 2 transmit, 3 good receive, 7 exception
// - end-of-service write pops context and ends the service
module gicx_global_ctx #(
	parameter logic [7:0] FW_REVISION = 8'h5a, // arbitrary value
	parameter int         RX_DEPTH    = gicx_pkg::RX_FIFO_DEPTH
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   cs_n,
	input  wire logic                   rd_n,
	input  wire logic                   wr_n,
	input  wire logic [6:0]             addr,
	input  wire logic [7:0]             data_in,
	output logic      [7:0]             data_out,
	output logic                        data_oe,
	input  wire logic                   int_ack_input_n,
	input  wire logic [2:0]             req_channel,
	input  wire logic                   req_rx_exception,
	output logic                        ack_taken,
	output logic                        in_service,
	output logic      [2:0]             int_group_code,
	output logic                        service_done_strobe,
	output logic      [3:0]             channel_addr,
	output logic                        tick,
	input  wire logic                   rx_valid,
	input  wire gicx_pkg::gicx_rx_char_t rx_char,
	input  wire logic                   rx_timeout,
	output logic                        rx_ready
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		gicx_pkg::gicx_state_t st;
		logic [7:0]            scn_user;
		logic [2:0]            scn_chan;
		logic [7:0]            lvl_modem;
		logic [7:0]            lvl_tx;
		logic [7:0]            lvl_rx;
		logic [7:0]            csel;
		logic [7:0]            fw;
		logic [7:0]            pre_hi;
		logic [7:0]            pre_lo;
		logic [15:0]           pre_cnt;
		logic                  tick;
		logic                  rd_prev;
		logic                  wr_prev;
		logic                  ack_prev;
		logic [7:0]            dout;
		logic                  doe;
		logic [2:0]            grp;
		logic                  done;
		logic                  ack_taken;
		logic                  hold_vld;
		gicx_pkg::gicx_entry_t hold;
		logic [3:0]            chan_addr;
		logic                  rx_rdy;
	} gicx_ctx_st_t;

	gicx_ctx_st_t          s_r;
	gicx_ctx_st_t          s_nxt;
	gicx_pkg::gicx_entry_t fifo_head;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_pop;
	logic                  rd_ev;
	logic                  wr_ev;
	logic                  ack_ev;
	logic                  serving;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic level_hit(input logic [7:0] lvl,
		input logic [6:0] a);
		level_hit = (lvl == {1'b1, a});
	endfunction : level_hit

	function automatic logic [2:0] sc_code(
		input gicx_pkg::gicx_rx_char_t c);
		sc_code = gicx_pkg::SC_NONE;
		if (!c.parity_error_flag && !c.framing_error_flag)
		begin
			unique case (c.match_index)
				3'h1: sc_code = gicx_pkg::SC_FIRST;
				3'h2: sc_code = gicx_pkg::SC_SECOND;
				3'h3: sc_code = (c.pair13_en && c.seq_matched) ?
					gicx_pkg::SC_FIRST : (c.pair13_en ?
					gicx_pkg::SC_NONE : gicx_pkg::SC_THIRD);
				3'h4: sc_code = (c.pair24_en && c.seq_matched) ?
					gicx_pkg::SC_SECOND : (c.pair24_en ?
					gicx_pkg::SC_NONE : gicx_pkg::SC_FOURTH);
				default: sc_code = gicx_pkg::SC_NONE;
			endcase
		end
	endfunction : sc_code

	// ------------------------------------------------------------------
	// strobe edges
	// ------------------------------------------------------------------
	assign serving = (s_r.st == gicx_pkg::ST_SERVICE);
	assign rd_ev   = !cs_n && !rd_n && s_r.rd_prev;
	assign wr_ev   = !cs_n && !wr_n && s_r.wr_prev;
	assign ack_ev  = !int_ack_input_n && s_r.ack_prev;
	assign fifo_pop = rd_ev && serving
		&& (addr == gicx_pkg::OFS_RX_BYTE_POP);

	// ------------------------------------------------------------------
	// receive buffer
	// ------------------------------------------------------------------
	gicx_fifo #(
		.WIDTH (gicx_pkg::ENTRY_W),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (s_r.hold_vld),
		.in_ready  (fifo_in_ready),
		.in_data   (s_r.hold),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_head)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.tick      = 1'b0;
		s_nxt.done      = 1'b0;
		s_nxt.ack_taken = 1'b0;
		s_nxt.rd_prev   = cs_n || rd_n;
		s_nxt.wr_prev   = cs_n || wr_n;
		s_nxt.ack_prev  = int_ack_input_n;

		// acknowledge and service context
		unique case (s_r.st)
			gicx_pkg::ST_IDLE:
			begin
				if (ack_ev)
				begin
					if (level_hit(s_r.lvl_modem, addr))
						s_nxt.grp = gicx_pkg::GRP_MODEM;
					else if (level_hit(s_r.lvl_tx, addr))
						s_nxt.grp = gicx_pkg::GRP_TRANSMIT;
					else if (level_hit(s_r.lvl_rx, addr))
						s_nxt.grp = req_rx_exception ?
							gicx_pkg::GRP_RX_EXCEPTION :
							gicx_pkg::GRP_RX_GOOD;
					if (level_hit(s_r.lvl_modem, addr)
						|| level_hit(s_r.lvl_tx, addr)
						|| level_hit(s_r.lvl_rx, addr))
					begin
						s_nxt.st        = gicx_pkg::ST_SERVICE;
						s_nxt.scn_chan  = req_channel;
						s_nxt.ack_taken = 1'b1;
					end
				end
			end
			gicx_pkg::ST_SERVICE:
			begin
				if (wr_ev && addr == gicx_pkg::OFS_SERVICE_DONE)
				begin
					s_nxt.st   = gicx_pkg::ST_IDLE;
					s_nxt.grp  = gicx_pkg::GRP_NONE;
					s_nxt.done = 1'b1;
				end
			end
		endcase

		// register writes
		if (wr_ev)
		begin
			unique case (addr)
				gicx_pkg::OFS_SERVICED_CHANNEL_NUMBER:
					s_nxt.scn_user = data_in
						& gicx_pkg::SCN_USER_MASK;
				gicx_pkg::OFS_ACK_LEVEL_MODEM_GROUP:
					s_nxt.lvl_modem = data_in;
				gicx_pkg::OFS_ACK_LEVEL_TRANSMIT_GRP:
					s_nxt.lvl_tx = data_in;
				gicx_pkg::OFS_ACK_LEVEL_RECEIVE_GROUP:
					s_nxt.lvl_rx = data_in;
				gicx_pkg::OFS_CHANNEL_SELECT:
					s_nxt.csel = data_in;
				gicx_pkg::OFS_TICK_PRESCALE_HIGH:
					s_nxt.pre_hi = data_in;
				gicx_pkg::OFS_TICK_PRESCALE_LOW:
					s_nxt.pre_lo = data_in;
				default:
					s_nxt.fw = s_r.fw;
			endcase
		end

		// register reads
		s_nxt.doe = !cs_n && !rd_n;
		if (rd_ev)
		begin
			unique case (addr)
				gicx_pkg::OFS_SERVICED_CHANNEL_NUMBER:
					s_nxt.dout = s_r.scn_user
						| {3'h0, s_r.scn_chan, 2'h0};
				gicx_pkg::OFS_ACK_LEVEL_MODEM_GROUP:
					s_nxt.dout = s_r.lvl_modem;
				gicx_pkg::OFS_ACK_LEVEL_TRANSMIT_GRP:
					s_nxt.dout = s_r.lvl_tx;
				gicx_pkg::OFS_ACK_LEVEL_RECEIVE_GROUP:
					s_nxt.dout = s_r.lvl_rx;
				gicx_pkg::OFS_CHANNEL_SELECT:
					s_nxt.dout = s_r.csel;
				gicx_pkg::OFS_FIRMWARE_REVISION:
					s_nxt.dout = s_r.fw;
				gicx_pkg::OFS_TICK_PRESCALE_HIGH:
					s_nxt.dout = s_r.pre_hi;
				gicx_pkg::OFS_TICK_PRESCALE_LOW:
					s_nxt.dout = s_r.pre_lo;
				gicx_pkg::OFS_RX_BYTE_POP:
					s_nxt.dout = (serving && fifo_out_valid) ?
						fifo_head.data :
						gicx_pkg::READ_IDLE_VALUE;
				gicx_pkg::OFS_RX_CHAR_CONDITION:
					s_nxt.dout = (serving && fifo_out_valid) ?
						fifo_head.cond :
						gicx_pkg::READ_IDLE_VALUE;
				default:
					s_nxt.dout = gicx_pkg::READ_IDLE_VALUE;
			endcase
		end

		// tick prescaler
		if (s_r.pre_cnt <= 16'h0001)
		begin
			s_nxt.pre_cnt = {s_r.pre_hi, s_r.pre_lo};
			s_nxt.tick    = 1'b1;
		end
		else
			s_nxt.pre_cnt = 16'(s_r.pre_cnt - 16'h0001);

		// receive holding stage
		if (s_r.hold_vld && fifo_in_ready)
			s_nxt.hold_vld = 1'b0;
		if (rx_valid)
		begin
			if (!s_r.hold_vld || fifo_in_ready)
			begin
				s_nxt.hold_vld   = 1'b1;
				s_nxt.hold.data  = rx_char.data;
				s_nxt.hold.cond  = '0;
				s_nxt.hold.cond.brk = rx_char.brk;
				s_nxt.hold.cond.parity_error_flag =
					rx_char.parity_error_flag;
				s_nxt.hold.cond.framing_error_flag =
					rx_char.framing_error_flag;
				s_nxt.hold.cond.special_char_match_code =
					sc_code(rx_char);
			end
			else if (!rx_char.seq_second)
				s_nxt.hold.cond.overrun = 1'b1;
		end
		else if (rx_timeout && !s_r.hold_vld && !fifo_out_valid)
		begin
			s_nxt.hold_vld     = 1'b1;
			s_nxt.hold         = '0;
			s_nxt.hold.cond.timeout = 1'b1;
		end
		s_nxt.rx_rdy = !s_nxt.hold_vld;

		// channel part of channel register addresses
		s_nxt.chan_addr = (s_nxt.st == gicx_pkg::ST_SERVICE) ?
			{1'b0, s_nxt.scn_chan} :
			s_nxt.csel[gicx_pkg::CSEL_ADDR_W-1:0];
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s_r          <= '0;
			s_r.st       <= gicx_pkg::ST_IDLE;
			s_r.scn_user <= gicx_pkg::SCN_RST;
			s_r.lvl_modem <= gicx_pkg::ACK_LEVEL_RST;
			s_r.lvl_tx   <= gicx_pkg::ACK_LEVEL_RST;
			s_r.lvl_rx   <= gicx_pkg::ACK_LEVEL_RST;
			s_r.csel     <= gicx_pkg::CSEL_RST;
			s_r.fw       <= FW_REVISION;
			s_r.pre_hi   <= gicx_pkg::PRESCALE_RST;
			s_r.pre_lo   <= gicx_pkg::PRESCALE_RST;
			s_r.pre_cnt  <= {gicx_pkg::PRESCALE_RST,
				gicx_pkg::PRESCALE_RST};
			s_r.rd_prev  <= 1'b1;
			s_r.wr_prev  <= 1'b1;
			s_r.ack_prev <= 1'b1;
			s_r.rx_rdy   <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign data_out            = s_r.dout;
	assign data_oe             = s_r.doe;
	assign ack_taken           = s_r.ack_taken;
	assign in_service          = s_r.st[1];
	assign int_group_code      = s_r.grp;
	assign service_done_strobe = s_r.done;
	assign channel_addr        = s_r.chan_addr;
	assign tick                = s_r.tick;
	assign rx_ready            = s_r.rx_rdy;

endmodule : gicx_global_ctx

// [dv/gicx_global_ctx_props.sv]
/*
 * gicx_global_ctx_props: port assertions of the global context block.
 * assumes: bound into gicx_global_ctx, one clock, synchronous reset.
 */
`timescale 1ns/1ps
module gicx_global_ctx_props #(
	parameter int RX_DEPTH = 8
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [6:0] addr,
	input wire logic [7:0] data_in,
	input wire logic       data_oe,
	input wire logic       int_ack_input_n,
	input wire logic       ack_taken,
	input wire logic       in_service,
	input wire logic [2:0] int_group_code,
	input wire logic       service_done_strobe,
	input wire logic [3:0] channel_addr,
	input wire logic       rx_valid,
	input wire logic       rx_ready
);
	// ------------------------------------------------------------------
	// port relations
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_oe_on; !cs_n && !rd_n |=> data_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("read enable late");
	property p_oe_off; cs_n || rd_n |=> !data_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("read enable stuck");
	property p_ack_edge;
		ack_taken |-> $past(int_ack_input_n, 2) && !$past(int_ack_input_n)
			&& !$past(in_service);
	endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("bad ack cause");
	property p_ack_ctx;
		ack_taken |-> in_service && channel_addr[3] == 1'b0 ##1 !ack_taken;
	endproperty
	a_ack_ctx: assert property (p_ack_ctx) else $error("ack context");
	property p_svc_chan; in_service |-> channel_addr[3] == 1'b0; endproperty
	a_svc_chan: assert property (p_svc_chan) else $error("svc channel");
	property p_group;
		in_service ? int_group_code inside {3'h1, 3'h2, 3'h3, 3'h7}
			: int_group_code == 3'h0;
	endproperty
	a_group: assert property (p_group) else $error("group code");
	property p_done;
		$fell(wr_n) && !cs_n && addr == 7'h7f && in_service
			|=> service_done_strobe && !in_service ##1 !service_done_strobe;
	endproperty
	a_done: assert property (p_done) else $error("service end");
	property p_csel;
		$fell(wr_n) && !cs_n && addr == 7'h64 && !in_service
			|=> channel_addr == $past(data_in[3:0]);
	endproperty
	a_csel: assert property (p_csel) else $error("channel select");
	property p_rx_hold; rx_valid |=> !rx_ready; endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx ready");

	c_ack: cover property (ack_taken);
	c_done: cover property (service_done_strobe);
	c_full: cover property (rx_valid && !rx_ready);
endmodule : gicx_global_ctx_props

// [dv/gicx_host_model.sv]
/*
 * gicx_host_model: host processor on the parallel bus with read, write
 * and interrupt acknowledge cycles as tasks.
 * assumes: tasks are called from the bench on clk_sys.
 */
`timescale 1ns/1ps
module gicx_host_model (
	input  wire logic       clk_sys,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic      [6:0] addr,
	output logic      [7:0] data_in,
	output logic            int_ack_input_n,
	input  wire logic [7:0] data_out
);
	// ------------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------------
	initial
	begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 7'h00;
		data_in = 8'h00;
		int_ack_input_n = 1'b1;
	end

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		repeat (2) @(posedge clk_sys);
		d = data_out;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		data_in <= d;
		repeat (2) @(posedge clk_sys);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		data_in <= ~d;
	endtask : wr

	task automatic ack(input logic [6:0] code);
		@(posedge clk_sys);
		int_ack_input_n <= 1'b0;
		addr <= code;
		repeat (2) @(posedge clk_sys);
		int_ack_input_n <= 1'b1;
	endtask : ack
endmodule : gicx_host_model

// [dv/test_gicx_global_ctx.sv]
/*
 * test_gicx_global_ctx: self-checking bench of the global context block.
 * assumes: host model drives the bus, bench drives scanner and receiver.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_gicx_global_ctx;
	localparam logic [9:0] FLG [8] = '{10'h010, 10'h020, 10'h110, 10'h030,
		10'h041, 10'h280, 10'h040, 10'h03a};
	localparam logic [7:0] CND [8] = '{8'h10, 8'h20, 8'h04, 8'h30, 8'h00,
		8'h0a, 8'h40, 8'h10};
	logic clk_sys, rst, cs_n, rd_n, wr_n, data_oe, int_ack_input_n;
	logic ack_taken, in_service, service_done_strobe, tick;
	logic req_rx_exception, rx_valid, rx_timeout, rx_ready;
	logic [6:0] addr;
	logic [7:0] data_in, data_out, d;
	logic [2:0] req_channel, int_group_code;
	logic [3:0] channel_addr;
	gicx_pkg::gicx_rx_char_t rx_char;
	int failures = 0;
	int total_checks = 0;
	int n, i;

	gicx_global_ctx #(.FW_REVISION(8'h3c)) gicx_global_ctx_inst (.*);
	gicx_host_model gicx_host_model_inst (.*);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic complete_run;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic enter(input logic [6:0] code, input logic [2:0] ch,
		input logic exc, input logic [2:0] grp);
		@(posedge clk_sys);
		req_channel <= ch;
		req_rx_exception <= exc;
		gicx_host_model_inst.ack(code);
		@(negedge clk_sys);
		`CHK(in_service, 1'b1)
		`CHK(int_group_code, grp)
		`CHK(channel_addr, {1'b0, ch})
		gicx_host_model_inst.rd(7'h41, d);
		`CHK(d, 8'he3 | {3'h0, ch, 2'h0})
	endtask : enter

	task automatic leave;
		gicx_host_model_inst.wr(7'h7f, 8'h00);
		@(negedge clk_sys);
		`CHK(in_service, 1'b0)
		`CHK(channel_addr, 4'h5)
	endtask : leave

	task automatic send(input logic [7:0] base, input logic [9:0] flg,
		input int cnt);
		for (int k = 0; k < 20 && rx_ready !== 1'b1; k++)
			@(negedge clk_sys);
		@(posedge clk_sys);
		for (int k = 0; k < cnt; k++)
		begin
			rx_valid <= 1'b1;
			rx_char <= {base + 8'(k), flg};
			@(posedge clk_sys);
		end
		rx_valid <= 1'b0;
		rx_char <= gicx_pkg::gicx_rx_char_t'(~rx_char);
	endtask : send

	// ------------------------------------------------------------------
	// clock, watchdog and sequence
	// ------------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (96000) @(posedge clk_sys);
		failures++;
		complete_run();
	end

	initial
	begin
		rst = 1'b1;
		req_channel = 3'h0;
		req_rx_exception = 1'b0;
		rx_valid = 1'b0;
		rx_char = '0;
		rx_timeout = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		gicx_host_model_inst.rd(7'h70, d);
		`CHK(d, 8'hff)
		gicx_host_model_inst.rd(7'h71, d);
		`CHK(d, 8'hff)
		gicx_host_model_inst.wr(7'h6b, 8'h00);
		gicx_host_model_inst.rd(7'h6b, d);
		`CHK(d, 8'h3c)
		gicx_host_model_inst.rd(7'h10, d);
		`CHK(d, 8'h00)
		gicx_host_model_inst.rd(7'h78, d);
		`CHK(d, 8'h00)
		gicx_host_model_inst.wr(7'h64, 8'h05);
		gicx_host_model_inst.rd(7'h64, d);
		`CHK(d, 8'h05)
		gicx_host_model_inst.wr(7'h41, 8'hff);
		for (i = 0; i < 3; i++)
		begin
			gicx_host_model_inst.wr(7'h61 + 7'(i), 8'h85 + 8'(i));
			gicx_host_model_inst.rd(7'h61 + 7'(i), d);
			`CHK(d, 8'h85 + 8'(i))
		end
		gicx_host_model_inst.wr(7'h61, 8'h05);
		gicx_host_model_inst.ack(7'h05);
		@(negedge clk_sys);
		`CHK(in_service, 1'b0)
		gicx_host_model_inst.wr(7'h61, 8'h85);
		for (i = 0; i < 2; i++)
		begin
			enter(7'h05 + 7'(i), 3'(3 * i + 1), 1'b0, 3'(i + 1));
			leave();
		end
		for (i = 0; i < 8; i++)
			send(8'h41 + 8'(i), FLG[i], 1);
		enter(7'h07, 3'h2, 1'b0, 3'h3);
		for (i = 0; i < 8; i++)
		begin
			gicx_host_model_inst.rd(7'h7a, d);
			`CHK(d, CND[i])
			gicx_host_model_inst.rd(7'h7a, d);
			`CHK(d, CND[i])
			gicx_host_model_inst.rd(7'h78, d);
			`CHK(d, 8'h41 + 8'(i))
		end
		leave();
		send(8'h80, 10'h000, 10);
		enter(7'h07, 3'h6, 1'b0, 3'h3);
		for (i = 0; i < 9; i++)
		begin
			gicx_host_model_inst.rd(7'h7a, d);
			`CHK(d, (i == 8) ? 8'h01 : 8'h00)
			gicx_host_model_inst.rd(7'h78, d);
			`CHK(d, 8'h80 + 8'(i))
		end
		leave();
		@(posedge clk_sys);
		rx_timeout <= 1'b1;
		@(posedge clk_sys);
		rx_timeout <= 1'b0;
		enter(7'h07, 3'h0, 1'b1, 3'h7);
		gicx_host_model_inst.rd(7'h7a, d);
		`CHK(d, 8'h80)
		gicx_host_model_inst.rd(7'h78, d);
		`CHK(d, 8'h00)
		leave();
		gicx_host_model_inst.wr(7'h70, 8'h61);
		gicx_host_model_inst.wr(7'h71, 8'ha8);
		for (n = 0; n < 70000 && tick !== 1'b1; n++)
			@(negedge clk_sys);
		n = 1;
		@(negedge clk_sys);
		while (tick !== 1'b1 && n < 30000)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(n, 25000)
		complete_run();
	end
endmodule : test_gicx_global_ctx

bind gicx_global_ctx gicx_global_ctx_props #(.RX_DEPTH(RX_DEPTH))
	gicx_global_ctx_props_inst (.*);
